/* File: verilog/ccrb_consts.vh */
`ifndef CCRB_CONSTS_VH
`define CCRB_CONSTS_VH

// ----------------------------------------------------------------
// register map (attribute memory byte addresses)
// ----------------------------------------------------------------
`define CCRB_BASE_ADDR      11'h200
`define CCRB_OFF_CFG_OPT    11'h000
`define CCRB_OFF_CFG_STAT   11'h002
`define CCRB_OFF_PIN_REPL   11'h004
`define CCRB_OFF_SOCK_COPY  11'h006

// ----------------------------------------------------------------
// configuration option fields
// ----------------------------------------------------------------
`define CCRB_OPT_SOFTRST_BIT 7
`define CCRB_OPT_LEVIRQ_BIT 6
`define CCRB_OPT_INDEX_MSB  5

// ----------------------------------------------------------------
// configuration and status fields
// ----------------------------------------------------------------
`define CCRB_CS_CHANGED_BIT 7
`define CCRB_CS_CHGSIG_BIT  6
`define CCRB_CS_IO8_BIT     5
`define CCRB_CS_PL1DIS_BIT  4
`define CCRB_CS_AUDIO_BIT   3
`define CCRB_CS_PWRDN_BIT   2
`define CCRB_CS_INT_BIT     1

// ----------------------------------------------------------------
// pin replacement fields
// ----------------------------------------------------------------
`define CCRB_PR_CRDY_BIT    5
`define CCRB_PR_CWP_BIT     4
`define CCRB_PR_MRDY_BIT    1
`define CCRB_PR_MWP_BIT     0

// ----------------------------------------------------------------
// socket and copy fields, index codes, reset byte, power settle and idle counts
// ----------------------------------------------------------------
`define CCRB_SC_DRIVE_BIT   4
`define CCRB_IDX_MEMORY     6'h00
`define CCRB_IDX_IO_ANY     6'h01
`define CCRB_IDX_IO_PRI     6'h02
`define CCRB_IDX_IO_SEC     6'h03
`define CCRB_RESET_BYTE     8'h00
`define CCRB_PWR_SETTLE     8'h08
`define CCRB_IDLE_COUNT     16'h03e8

`endif

/* File: verilog/ccrb_power_seq.v */
`timescale 1ns/1ns
`include "ccrb_consts.vh"

// ----------------------------------------------------------------
// power state sequencer: busy while a new power state settles
// ----------------------------------------------------------------
module ccrb_power_seq #(
  parameter SETTLE_CYCLES = 8
) (
  // clock and reset
  input  wire mclk,
  input  wire reset,
  // requests
  input  wire pwrReq,
  // status
  output reg  pwrState,
  output wire pwrBusy
);

  reg [7:0] settleCnt_reg;

  // count down after each change of the requested state
  always @(posedge mclk) begin
    if (reset) begin
      pwrState      <= 1'b0;
      settleCnt_reg <= 8'h00;
    end else if (pwrReq != pwrState && settleCnt_reg == 8'h00) begin
      settleCnt_reg <= SETTLE_CYCLES[7:0];
    end else if (settleCnt_reg == 8'h01) begin
      settleCnt_reg <= 8'h00;
      pwrState      <= pwrReq;
    end else if (settleCnt_reg != 8'h00) begin
      settleCnt_reg <= settleCnt_reg - 8'h01;
    end
  end

  // busy until the requested state is reached
  assign pwrBusy = (pwrReq != pwrState);

endmodule

/* File: verilog/ccrb_card_config.v */
`timescale 1ns/1ns
`include "ccrb_consts.vh"

module ccrb_card_config #(
  parameter SETTLE_CYCLES = `CCRB_PWR_SETTLE,
  parameter IDLE_CYCLES   = `CCRB_IDLE_COUNT,
  parameter DRIVE_NUM_SUP = 1
) (
  // clock and hardware reset
  input  wire       mclk,
  input  wire       reset,
  // attribute memory access (synchronous strobes)
  input  wire       regSpace,
  input  wire       cardSel,
  input  wire [10:0] addr,
  input  wire       rdStb,
  input  wire       wrStb,
  input  wire [7:0] wrData,
  output reg  [7:0] rdData,
  // card core status
  input  wire       coreReady,
  input  wire       coreIrq,
  input  wire       irqDisableControl,
  input  wire       cmdStart,
  input  wire       coreIdle,
  // configuration outputs
  output wire       cardReset,
  output wire       hardResetToAta,
  output wire       levelIrqSelect,
  output wire [5:0] configIndex,
  output wire       memMapped,
  output wire       ioAnyBoundary,
  output wire       ioPrimary,
  output wire       ioSecondary,
  output wire       ioConfigured,
  output wire       driveNumber,
  output wire       powerDownState,
  output wire       readyOut,
  output wire       statusChangeLine_n
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg        softReset_reg;
  reg        levelIrq_reg;
  reg [5:0]  cfgIndex_reg;
  reg        statusSigEn_reg;
  reg        pl1Disable_reg;
  reg        pwrDownReq_reg;
  reg        autoDown_reg;
  reg        readyChg_reg;
  reg        wpChg_reg;
  reg        driveNum_reg;
  reg        readyPrev_reg;
  reg        wpPrev_reg;
  reg [15:0] idleCnt_reg;

  wire       internalReset;
  wire       accessHit;
  wire       wrHit;
  wire       pwrBusy;
  wire       readyState;
  wire       wpState;
  wire       changedBit;
  wire       intPending;
  wire       pwrReq;
  reg  [7:0] rdData_next;
  reg        wrOpt;
  reg        wrStat;
  reg        wrPin;
  reg        wrSock;
  wire       readyToggle;
  wire       wpToggle;
  wire       rdTake;

  // decode an even, in-range configuration address
  function hit;
    input [10:0] a;
    input [10:0] off;
    begin
      hit = (a == (`CCRB_BASE_ADDR + off));
    end
  endfunction

  // ----------------------------------------------------------------
  // reset and decode
  // ----------------------------------------------------------------
  // soft reset equivalence
  assign internalReset  = reset | softReset_reg;
  assign cardReset      = internalReset;
  assign hardResetToAta = internalReset;
  assign accessHit      = regSpace & cardSel & ~addr[0];
  assign wrHit          = accessHit & wrStb;
  // any selected read is answered, so a refused one returns zero
  assign rdTake         = regSpace & cardSel & rdStb;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // one target per write
  always @* begin
    wrOpt  = 1'b0;
    wrStat = 1'b0;
    wrPin  = 1'b0;
    wrSock = 1'b0;
    if (!wrHit) begin
      wrOpt = 1'b0;
    end else if (hit(addr, `CCRB_OFF_CFG_OPT)) begin
      wrOpt = 1'b1;
    end else if (hit(addr, `CCRB_OFF_CFG_STAT)) begin
      wrStat = 1'b1;
    end else if (hit(addr, `CCRB_OFF_PIN_REPL)) begin
      wrPin = 1'b1;
    end else if (hit(addr, `CCRB_OFF_SOCK_COPY)) begin
      wrSock = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration option register
  // ----------------------------------------------------------------
  // soft reset bit only sees hardware reset; it keeps itself set
  always @(posedge mclk) begin
    if (reset) begin
      softReset_reg <= 1'b0;
    end else if (wrOpt) begin
      // option at offset zero
      // kept as written, so the host must write 0 to leave reset
      softReset_reg <= wrData[`CCRB_OPT_SOFTRST_BIT];
    end
  end

  // remaining option fields, cleared while any reset is active
  always @(posedge mclk) begin
    if (internalReset) begin
      levelIrq_reg <= 1'b0;
      cfgIndex_reg <= 6'h00;
    end else if (wrOpt) begin
      levelIrq_reg <= wrData[`CCRB_OPT_LEVIRQ_BIT];
      // six-bit index, reserved bits stored as written
      cfgIndex_reg <= wrData[`CCRB_OPT_INDEX_MSB:0];
    end
  end

  // option fields straight to the pins
  assign levelIrqSelect = levelIrq_reg;
  assign configIndex    = cfgIndex_reg;

  assign memMapped     = (cfgIndex_reg == `CCRB_IDX_MEMORY);
  assign ioAnyBoundary = (cfgIndex_reg == `CCRB_IDX_IO_ANY);
  assign ioPrimary     = (cfgIndex_reg == `CCRB_IDX_IO_PRI);
  assign ioSecondary   = (cfgIndex_reg == `CCRB_IDX_IO_SEC);
  // reserved index values leave the card unconfigured for I/O
  assign ioConfigured  = ioAnyBoundary | ioPrimary | ioSecondary;

  // ----------------------------------------------------------------
  // configuration and status register
  // ----------------------------------------------------------------
  // eight-bit request and audio bits are not stored at all
  always @(posedge mclk) begin
    if (internalReset) begin
      statusSigEn_reg <= 1'b0;
      pl1Disable_reg  <= 1'b0;
      pwrDownReq_reg  <= 1'b0;
    end else if (wrStat) begin
      statusSigEn_reg <= wrData[`CCRB_CS_CHGSIG_BIT];
      pl1Disable_reg <= 1'b0;
      pwrDownReq_reg <= wrData[`CCRB_CS_PWRDN_BIT];
    end
  end

  // idle timer drops to power down, command wakes
  always @(posedge mclk) begin
    if (internalReset || cmdStart || !coreIdle) begin
      idleCnt_reg  <= 16'h0000;
      autoDown_reg <= 1'b0;
    end else if (idleCnt_reg == IDLE_CYCLES[15:0]) begin
      // count stops at the limit, so it never wraps back
      autoDown_reg <= 1'b1;
    end else begin
      idleCnt_reg <= idleCnt_reg + 16'h0001;
    end
  end

  // host request or idle timer may ask for power-down
  assign pwrReq = pwrDownReq_reg | autoDown_reg;

  // settle timer kept apart so its length can be tuned alone
  ccrb_power_seq #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) uPower (
    .mclk     (mclk),
    .reset    (internalReset),
    .pwrReq   (pwrReq),
    .pwrState (powerDownState),
    .pwrBusy  (pwrBusy)
  );

  assign readyState = coreReady & ~pwrBusy & ~internalReset;
  assign readyOut   = readyState;
  // no write-protect switch, so its state is fixed low
  assign wpState    = 1'b0;

  // pending mirrors irq, zero when disabled
  assign intPending = coreIrq & ~irqDisableControl;

  // ----------------------------------------------------------------
  // pin replacement change flags
  // ----------------------------------------------------------------
  // toggles against last cycle
  assign readyToggle = (readyState != readyPrev_reg);
  assign wpToggle    = (wpState != wpPrev_reg);

  // last-cycle copies for the toggle detectors
  always @(posedge mclk) begin
    if (internalReset) begin
      readyPrev_reg <= 1'b0;
      wpPrev_reg    <= 1'b0;
    end else begin
      readyPrev_reg <= readyState;
      wpPrev_reg    <= wpState;
    end
  end

  // ready change flag: hardware set wins over a same-cycle host clear
  always @(posedge mclk) begin
    if (internalReset) begin
      readyChg_reg <= 1'b0;
    end else if (readyToggle) begin
      readyChg_reg <= 1'b1;
    end else if (wrPin && wrData[`CCRB_PR_MRDY_BIT]) begin
      readyChg_reg <= wrData[`CCRB_PR_CRDY_BIT];
    end
  end

  // write-protect change flag; only the host moves it here
  always @(posedge mclk) begin
    if (internalReset) begin
      wpChg_reg <= 1'b0;
    end else if (wpToggle) begin
      wpChg_reg <= 1'b1;
    end else if (wrPin && wrData[`CCRB_PR_MWP_BIT]) begin
      wpChg_reg <= wrData[`CCRB_PR_CWP_BIT];
    end
  end

  assign changedBit = readyChg_reg | wpChg_reg;

  // line low only when enabled and I/O configured
  assign statusChangeLine_n = ~(changedBit & statusSigEn_reg & ioConfigured);

  // ----------------------------------------------------------------
  // socket and copy register
  // ----------------------------------------------------------------
  // drive number kept; socket bits dropped on write
  always @(posedge mclk) begin
    if (internalReset) begin
      driveNum_reg <= 1'b0;
    end else if (wrSock) begin
      driveNum_reg <= (DRIVE_NUM_SUP != 0) ? wrData[`CCRB_SC_DRIVE_BIT] : 1'b0;
    end
  end

  // drive number for the twin-card match
  assign driveNumber = driveNum_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux; unmapped attribute addresses return zero
  always @* begin
    rdData_next = `CCRB_RESET_BYTE;
    // odd or unmapped addresses fall through to zero
    if (hit(addr, `CCRB_OFF_CFG_OPT)) begin
      rdData_next = {softReset_reg, levelIrq_reg, cfgIndex_reg};
    end else if (hit(addr, `CCRB_OFF_CFG_STAT)) begin
      rdData_next = {changedBit, statusSigEn_reg, 1'b0, pl1Disable_reg,
                     1'b0, pwrDownReq_reg, intPending, 1'b0};
    end else if (hit(addr, `CCRB_OFF_PIN_REPL)) begin
      rdData_next = {2'b00, readyChg_reg, wpChg_reg, 2'b11, readyState, wpState};
    end else if (hit(addr, `CCRB_OFF_SOCK_COPY)) begin
      rdData_next = {3'b000, driveNum_reg, 4'h0};
    end
  end

  // registered read data, captured on the read strobe
  always @(posedge mclk) begin
    // hardware reset only: soft reset keeps the last answer
    if (reset) begin
      rdData <= `CCRB_RESET_BYTE;
    end else if (rdTake) begin
      rdData <= rdData_next;
    end
  end

endmodule

/* File: verif/ccrb_card_config_sva.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// checker on the register bank pins
// ----------------------------------------------------------------
module ccrb_card_config_sva (
  // clock and reset
  input wire        mclk,
  input wire        reset,
  // attribute access
  input wire        regSpace,
  input wire        cardSel,
  input wire [10:0] addr,
  input wire        rdStb,
  input wire        wrStb,
  input wire [7:0]  wrData,
  input wire [7:0]  rdData,
  // core and configuration
  input wire        irqDisableControl,
  input wire        cardReset,
  input wire        hardResetToAta,
  input wire        levelIrqSelect,
  input wire [5:0]  configIndex,
  input wire        memMapped,
  input wire        ioAnyBoundary,
  input wire        ioConfigured,
  input wire        powerDownState,
  input wire        readyOut,
  input wire        statusChangeLine_n
);
  // host read select; csr write that flips the power request
  wire rdSel = rdStb && regSpace && cardSel;
  wire pwrFlip = wrStb && regSpace && cardSel && addr == 11'h202 && !cardReset
                 && wrData[2] != powerDownState;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  soft_rst_clr_a: assert property (
    cardReset && $past(cardReset) |-> hardResetToAta && configIndex == 6'h00 && !levelIrqSelect)
    else $error("soft reset left state");
  index_decode_a: assert property (
    configIndex[5:2] == 4'h0 |-> memMapped == (configIndex == 6'h00)
    && ioAnyBoundary == (configIndex == 6'h01) && ioConfigured == (configIndex != 6'h00))
    else $error("index decode wrong");
  chg_line_io_a: assert property (
    !statusChangeLine_n |-> ioConfigured) else $error("status line low in memory mode");
  pwr_busy_a: assert property (
    pwrFlip |=> !readyOut [*2]) else $error("ready not busy on power change");
  rd_refused_a: assert property (
    rdSel && (addr[0] || addr == 11'h208) |=> rdData == 8'h00) else $error("refused read not 0");
  pin_layout_a: assert property (
    rdSel && addr == 11'h204 |=> rdData[7:6] == 2'b00 && rdData[3:2] == 2'b11 && !rdData[0])
    else $error("pin replacement layout");
  sock_low_a: assert property (
    rdSel && addr == 11'h206 |=> rdData[6:5] == 2'b00 && rdData[3:0] == 4'h0)
    else $error("socket bits not 0");
  csr_fixed_a: assert property (
    rdSel && addr == 11'h202 |=> rdData[5:3] == 3'b000 && !rdData[0]) else $error("csr fixed bits");
  int_masked_a: assert property (
    rdSel && addr == 11'h202 && irqDisableControl |=> !rdData[1]) else $error("int not masked");
  reset_clear_a: assert property (
    $fell(reset) |-> rdData == 8'h00 && configIndex == 6'h00 && !levelIrqSelect && !cardReset)
    else $error("reset values wrong");
endmodule

bind ccrb_card_config ccrb_card_config_sva u_sva (.mclk(mclk), .reset(reset),
  .regSpace(regSpace), .cardSel(cardSel), .addr(addr), .rdStb(rdStb), .wrStb(wrStb),
  .wrData(wrData), .rdData(rdData), .irqDisableControl(irqDisableControl),
  .cardReset(cardReset), .hardResetToAta(hardResetToAta), .levelIrqSelect(levelIrqSelect),
  .configIndex(configIndex), .memMapped(memMapped), .ioAnyBoundary(ioAnyBoundary),
  .ioConfigured(ioConfigured), .powerDownState(powerDownState), .readyOut(readyOut),
  .statusChangeLine_n(statusChangeLine_n));

/* File: verif/ccrb_host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host socket controller: byte attribute cycles
// ----------------------------------------------------------------
module ccrb_host_model (
  // clock
  input  wire        mclk,
  // attribute cycle pins
  output reg         regSpace,
  output reg         cardSel,
  output reg  [10:0] addr,
  output reg         rdStb,
  output reg         wrStb,
  output reg  [7:0]  wrData,
  input  wire [7:0]  rdData
);
  initial {regSpace, cardSel, rdStb, wrStb, addr, wrData} = 23'h0;
  // one byte cycle held over one rising edge, moved on falling edges
  task cyc(input [10:0] a, input w, input [7:0] v);
    @(negedge mclk);
    {regSpace, cardSel, addr, wrData, wrStb, rdStb} = {2'b11, a, v, w, !w};
    @(negedge mclk);
    // released address and data lines show the inverse so a stale value never matches
    {regSpace, cardSel, wrStb, rdStb} = 4'h0;
    addr = ~addr;
    wrData = ~wrData;
  endtask
  task wr(input [10:0] a, input [7:0] v);
    cyc(a, 1'b1, v);
  endtask
  // read byte is registered, so it is taken on the release edge
  task rd(input [10:0] a, output [7:0] v);
    cyc(a, 1'b0, 8'h00);
    v = rdData;
  endtask
endmodule

/* File: verif/test_card_config_register_bank.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// self-checking bench for the register bank
// ----------------------------------------------------------------
module test_card_config_register_bank;
  reg         mclk = 1'b0;
  reg         reset = 1'b1;
  reg         coreReady = 1'b1;
  reg         coreIrq = 1'b0;
  reg         irqDis = 1'b0;
  reg         cmdStart = 1'b0;
  reg         coreIdle = 1'b0;
  wire        regSpace, cardSel, rdStb, wrStb, cardReset, hardRst, levIrq, memMapped;
  wire        ioAny, ioPri, ioSec, ioCfg, driveNumber, pwrDown, readyOut, status_change_line_n;
  wire [10:0] addr;
  wire [7:0]  wrData, rdData;
  wire [5:0]  configIndex;
  integer     failCount = 0;
  integer     checksDone = 0;
  integer     i, n;
  reg  [7:0]  d;
  reg  [34:0] rows [0:8];
  always #5 mclk = ~mclk;
  ccrb_card_config #(.SETTLE_CYCLES(2), .IDLE_CYCLES(10)) dut (.mclk(mclk), .reset(reset),
    .regSpace(regSpace), .cardSel(cardSel), .addr(addr), .rdStb(rdStb), .wrStb(wrStb),
    .wrData(wrData), .rdData(rdData), .coreReady(coreReady), .coreIrq(coreIrq),
    .irqDisableControl(irqDis), .cmdStart(cmdStart), .coreIdle(coreIdle),
    .cardReset(cardReset), .hardResetToAta(hardRst), .levelIrqSelect(levIrq),
    .configIndex(configIndex), .memMapped(memMapped), .ioAnyBoundary(ioAny),
    .ioPrimary(ioPri), .ioSecondary(ioSec), .ioConfigured(ioCfg), .driveNumber(driveNumber),
    .powerDownState(pwrDown), .readyOut(readyOut), .statusChangeLine_n(status_change_line_n));
  ccrb_host_model hst (.mclk(mclk), .regSpace(regSpace), .cardSel(cardSel), .addr(addr),
    .rdStb(rdStb), .wrStb(wrStb), .wrData(wrData), .rdData(rdData));
  task giveVerdict;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk8(input [7:0] got, input [7:0] exp, input [7:0] m);
    checksDone = checksDone + 1;
    if ((got & m) !== (exp & m)) begin
      failCount = failCount + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rdc(input [10:0] a, input [7:0] exp, input [7:0] m);
    hst.rd(a, d);
    chk8(d, exp, m);
  endtask
  // bounded wait on ready (w=0) or power state (w=1); a hang ends the run
  task waitFor(input w, input v);
    n = 0;
    while ((w ? pwrDown : readyOut) !== v && n < 40) begin
      @(negedge mclk);
      n = n + 1;
    end
    if (n >= 40) begin
      failCount = failCount + 1;
      $display("[ERR] %0t wait ran out", $time);
      giveVerdict;
    end
  endtask
  initial begin
    // address, written byte, expected read, compare mask
    rows[0] = {11'h206, 8'h1f, 8'h10, 8'h7f};
    rows[1] = {11'h206, 8'h0f, 8'h00, 8'h7f};
    rows[2] = {11'h200, 8'h00, 8'h00, 8'hff};
    rows[3] = {11'h200, 8'h01, 8'h01, 8'hff};
    rows[4] = {11'h200, 8'h02, 8'h02, 8'hff};
    rows[5] = {11'h200, 8'h43, 8'h43, 8'hff};
    rows[6] = {11'h201, 8'h05, 8'h00, 8'hff};
    rows[7] = {11'h208, 8'h5a, 8'h00, 8'hff};
    rows[8] = {11'h202, 8'h30, 8'h00, 8'h7f};
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    rdc(11'h200, 8'h00, 8'hff);
    rdc(11'h202, 8'h00, 8'h7f);
    chk8({6'h00, memMapped, status_change_line_n}, 8'h03, 8'hff);
    hst.wr(11'h204, 8'h03);
    $display("reset test done");
    // socket register goes before the index; top bits kept zero
    for (i = 0; i < 9; i = i + 1) begin
      hst.wr(rows[i][34:24], rows[i][23:16]);
      rdc(rows[i][34:24], rows[i][15:8], rows[i][7:0]);
      if (rows[i][34:24] == 11'h200)
        chk8({levIrq, memMapped, ioAny, ioPri, ioSec, 1'b0, configIndex[1:0]}, {rows[i][22],
          rows[i][17:16] == 2'd0, rows[i][17:16] == 2'd1, rows[i][17:16] == 2'd2,
          rows[i][17:16] == 2'd3, 1'b0, rows[i][17:16]}, 8'hff);
      if (rows[i][34:24] == 11'h206)
        chk8({7'h00, driveNumber}, {7'h00, rows[i][20]}, 8'h01);
    end
    chk8({ioCfg, 1'b0, configIndex}, 8'h83, 8'hff);
    $display("table test done");
    hst.wr(11'h202, 8'h40);
    hst.wr(11'h204, 8'h33);
    rdc(11'h204, 8'h3c, 8'hfd);
    rdc(11'h202, 8'hc0, 8'hff);
    chk8({7'h00, status_change_line_n}, 8'h00, 8'h01);
    hst.wr(11'h204, 8'h00);
    rdc(11'h204, 8'h3c, 8'hfd);
    hst.wr(11'h202, 8'h00);
    chk8({7'h00, status_change_line_n}, 8'h01, 8'h01);
    hst.wr(11'h204, 8'h23);
    rdc(11'h204, 8'h2e, 8'hff);
    coreReady = 1'b0;
    hst.wr(11'h204, 8'h03);
    rdc(11'h204, 8'h0c, 8'hff);
    rdc(11'h202, 8'h00, 8'hff);
    coreReady = 1'b1;
    rdc(11'h204, 8'h2e, 8'hff);
    hst.wr(11'h204, 8'h03);
    $display("change flag test done");
    hst.wr(11'h202, 8'h04);
    chk8({7'h00, readyOut}, 8'h00, 8'h01);
    waitFor(1'b0, 1'b1);
    chk8({6'h00, n >= 1 && n <= 4, pwrDown}, 8'h03, 8'hff);
    rdc(11'h202, 8'h04, 8'h7f);
    hst.wr(11'h202, 8'h00);
    waitFor(1'b0, 1'b1);
    chk8({7'h00, pwrDown}, 8'h00, 8'h01);
    hst.wr(11'h204, 8'h03);
    coreIrq = 1'b1;
    rdc(11'h202, 8'h02, 8'h02);
    irqDis = 1'b1;
    rdc(11'h202, 8'h00, 8'h02);
    {coreIrq, irqDis} = 2'b00;
    $display("power and irq test done");
    hst.wr(11'h200, 8'hc1);
    @(negedge mclk);
    chk8({cardReset, hardRst, configIndex}, 8'hc0, 8'hff);
    rdc(11'h200, 8'h80, 8'hff);
    hst.wr(11'h200, 8'h00);
    chk8({cardReset, hardRst, memMapped, 5'h00}, 8'h20, 8'hff);
    $display("soft reset test done");
    coreIdle = 1'b1;
    waitFor(1'b1, 1'b1);
    {coreIdle, cmdStart} = 2'b01;
    @(negedge mclk);
    cmdStart = 1'b0;
    waitFor(1'b1, 1'b0);
    $display("idle test done");
    hst.wr(11'h200, 8'h41);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    rdc(11'h200, 8'h00, 8'hff);
    $display("second reset test done");
    giveVerdict;
  end
endmodule
